// File: pkg/clk_sel_pkg.sv
package clk_sel_pkg;
    localparam int NUM_PLL       = 4;
    localparam int NUM_PIN       = 4;
    localparam int NUM_SRC       = 2 * NUM_PLL + NUM_PIN;
    localparam int SRC_W         = 4;
    localparam int CORNER_PLL_LO = 2;
    localparam int NUM_QUAD      = 24;
    localparam int NUM_IOCLK     = 8;
    localparam int QUAD_W        = 5;
    localparam logic [SRC_W-1:0] STATIC_SRC_RST = 4'h0;

    typedef struct packed {
        logic [SRC_W-1:0] src_a;
        logic [SRC_W-1:0] src_b;
        logic             dynamic_en;
        logic [SRC_W-1:0] static_src;
    } global_cfg_type;

    typedef enum logic [1:0] {
        SEL_STATIC,
        SEL_DYN_A,
        SEL_DYN_B
    } sel_state_type;
endpackage

// File: hw/src_mux.sv
`timescale 1ns/1ps
module src_mux (
    input  wire logic [clk_sel_pkg::NUM_SRC-1:0] src_in,
    input  wire logic [clk_sel_pkg::SRC_W-1:0]   sel,
    output logic                                 src_out
);
    assign src_out = (sel < 4'(clk_sel_pkg::NUM_SRC)) ? src_in[sel] : 1'b0;
endmodule

// File: hw/clock_source_select_control.sv
`timescale 1ns/1ps
module clock_source_select_control (
    input  wire logic                                  sys_clk,
    input  wire logic                                  sys_rst,
    input  wire logic [clk_sel_pkg::NUM_SRC-1:0]       src_in,
    input  wire clk_sel_pkg::global_cfg_type           global_cfg,
    input  wire logic                                  dyn_sel,
    input  wire logic [clk_sel_pkg::SRC_W-1:0]         regional_cfg,
    input  wire logic [clk_sel_pkg::SRC_W-1:0]         ext_cfg,
    input  wire logic                                  ext_use_clock,
    input  wire logic                                  ext_internal_sig,
    input  wire logic [clk_sel_pkg::NUM_QUAD-1:0]      quad_clk,
    input  wire logic [clk_sel_pkg::NUM_IOCLK*clk_sel_pkg::QUAD_W-1:0]
                                                       ioclk_cfg,
    output logic                                       global_out,
    output logic                                       regional_out,
    output logic                                       ext_pin_out,
    output logic [clk_sel_pkg::NUM_IOCLK-1:0]          ioclk_out,
    output logic [clk_sel_pkg::SRC_W-1:0]              global_sel_q
);
    localparam int W = clk_sel_pkg::SRC_W;

    clk_sel_pkg::sel_state_type state_reg, state_next;
    logic [W-1:0] global_sel_next;
    logic         dyn_sel_reg;

    // corner pll counter outputs live at pll index CORNER_PLL_LO and up
    wire a_corner = global_cfg.src_a >= W'(2 * clk_sel_pkg::CORNER_PLL_LO)
                 && global_cfg.src_a < W'(2 * clk_sel_pkg::NUM_PLL);
    wire b_corner = global_cfg.src_b >= W'(2 * clk_sel_pkg::CORNER_PLL_LO)
                 && global_cfg.src_b < W'(2 * clk_sel_pkg::NUM_PLL);
    wire dyn_ok   = global_cfg.dynamic_en && !a_corner && !b_corner;

    always_comb begin
        unique case (state_reg)
            clk_sel_pkg::SEL_STATIC: state_next = dyn_ok ?
                (dyn_sel_reg ? clk_sel_pkg::SEL_DYN_B
                             : clk_sel_pkg::SEL_DYN_A)
                : clk_sel_pkg::SEL_STATIC;
            clk_sel_pkg::SEL_DYN_A, clk_sel_pkg::SEL_DYN_B: state_next =
                !dyn_ok ? clk_sel_pkg::SEL_STATIC
                : (dyn_sel_reg ? clk_sel_pkg::SEL_DYN_B
                               : clk_sel_pkg::SEL_DYN_A);
            default: state_next = clk_sel_pkg::SEL_STATIC;
        endcase
    end

    assign global_sel_next =
        (state_next == clk_sel_pkg::SEL_DYN_A) ? global_cfg.src_a :
        (state_next == clk_sel_pkg::SEL_DYN_B) ? global_cfg.src_b :
        global_cfg.static_src;

    // select registered so user changes land on a clock edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg    <= clk_sel_pkg::SEL_STATIC;
            dyn_sel_reg  <= 1'b0;
            global_sel_q <= clk_sel_pkg::STATIC_SRC_RST;
        end else begin
            dyn_sel_reg  <= dyn_sel;
            state_reg    <= state_next;
            global_sel_q <= global_sel_next;
        end
    end

    logic ext_ctrl_out;

    src_mux u_global (
        .src_in  (src_in),
        .sel     (global_sel_q),
        .src_out (global_out)
    );
    src_mux u_regional (
        .src_in  (src_in),
        .sel     (regional_cfg),
        .src_out (regional_out)
    );
    src_mux u_ext (
        .src_in  (src_in),
        .sel     (ext_cfg),
        .src_out (ext_ctrl_out)
    );

    assign ext_pin_out = ext_use_clock ? ext_ctrl_out
                                       : ext_internal_sig;

    // io clock region: eight picks from the quadrant resources
    genvar g;
    generate
        for (g = 0; g < clk_sel_pkg::NUM_IOCLK; g++) begin : g_io
            wire [clk_sel_pkg::QUAD_W-1:0] pick =
                ioclk_cfg[g*clk_sel_pkg::QUAD_W +: clk_sel_pkg::QUAD_W];
            assign ioclk_out[g] =
                (pick < 5'(clk_sel_pkg::NUM_QUAD)) ? quad_clk[pick]
                                                    : 1'b0;
        end
    endgenerate

    chk_dyn_pair: assert property (@(posedge sys_clk) disable iff (sys_rst)
        dyn_ok ##1 dyn_ok |-> global_sel_q ==
            ($past(dyn_sel_reg) ? $past(global_cfg.src_b)
                                : $past(global_cfg.src_a)))
        else $error("dynamic select left its pair");
    chk_static_any: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !dyn_ok && $stable(global_cfg) |=> global_sel_q ==
            $past(global_cfg.static_src))
        else $error("static select not applied");
    chk_corner_block: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (a_corner || b_corner) |=> state_reg == clk_sel_pkg::SEL_STATIC)
        else $error("corner pll chosen at run time");
    chk_mode_follow: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        dyn_ok |=> state_reg != clk_sel_pkg::SEL_STATIC)
        else $error("run-time mode not entered");
    chk_regional_cfg: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        regional_cfg < 4'(clk_sel_pkg::NUM_SRC) |->
            regional_out == src_in[regional_cfg])
        else $error("regional select wrong");
    chk_ext_pin: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ext_use_clock |-> ext_pin_out == ext_internal_sig)
        else $error("ext pin mux wrong");
    chk_ioclk_pick: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ioclk_cfg[4:0] < 5'(clk_sel_pkg::NUM_QUAD) |->
            ioclk_out[0] == quad_clk[ioclk_cfg[4:0]])
        else $error("io clock pick wrong");
    chk_sel_delay: assert property (@(posedge sys_clk) disable iff (sys_rst)
        dyn_ok && $stable(dyn_sel) ##1 dyn_ok && $stable(global_cfg)
        |=> $stable(global_sel_q))
        else $error("select moved without cause");

    // global output follows its registered select
    chk_global_route: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        global_sel_q < 4'(clk_sel_pkg::NUM_SRC) |->
            global_out == src_in[global_sel_q])
        else $error("global output not routed");

    // unused select codes give a quiet output
    chk_global_range: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        global_sel_q >= 4'(clk_sel_pkg::NUM_SRC) |->
            !global_out)
        else $error("global output not quiet");

    chk_regional_range: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        regional_cfg >= 4'(clk_sel_pkg::NUM_SRC) |->
            !regional_out)
        else $error("regional output not quiet");

    // external pin in clock mode
    chk_ext_clock: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        ext_use_clock && ext_cfg < 4'(clk_sel_pkg::NUM_SRC) |->
            ext_pin_out == src_in[ext_cfg])
        else $error("ext clock route wrong");

    chk_ioclk_top: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        ioclk_cfg[39:35] < 5'(clk_sel_pkg::NUM_QUAD) |->
            ioclk_out[7] == quad_clk[ioclk_cfg[39:35]])
        else $error("last io clock pick wrong");

    chk_ioclk_range: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        ioclk_cfg[4:0] >= 5'(clk_sel_pkg::NUM_QUAD) |->
            !ioclk_out[0])
        else $error("io clock not quiet");

    // leaving run-time mode returns to configuration
    chk_static_exit: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        !dyn_ok |=>
            state_reg == clk_sel_pkg::SEL_STATIC)
        else $error("static mode not restored");

    // run-time select held for two edges
    sequence seq_hold_a;
        dyn_ok && !dyn_sel && $stable(global_cfg)
        ##1 dyn_ok && $stable(global_cfg);
    endsequence
    sequence seq_hold_b;
        dyn_ok && dyn_sel && $stable(global_cfg)
        ##1 dyn_ok && $stable(global_cfg);
    endsequence

    chk_walk_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        seq_hold_a |=>
            global_sel_q == $past(global_cfg.src_a))
        else $error("first source not reached");

    chk_walk_b: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        seq_hold_b |=>
            global_sel_q == $past(global_cfg.src_b))
        else $error("second source not reached");

    // run-time mode never leaves the configured pair
    chk_pair_only: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        state_reg != clk_sel_pkg::SEL_STATIC |->
            (global_sel_q == $past(global_cfg.src_a)
             || global_sel_q == $past(global_cfg.src_b)))
        else $error("select outside pair");
endmodule

// File: verification/sel_driver.sv
`timescale 1ns/1ps
// user logic side: registered run-time select
module sel_driver (
    input  wire logic sys_clk,
    input  wire logic want_b,
    output logic      dyn_sel
);
    always_ff @(posedge sys_clk) begin
        dyn_sel <= want_b;
    end
endmodule

// File: verification/test_clock_source_select_control.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: output mismatch", $time); end end
module test_clock_source_select_control;
    logic                        sys_clk = 1'b0;
    logic                        sys_rst = 1'b1;
    logic [11:0]                 src_in = 12'h000;
    clk_sel_pkg::global_cfg_type global_cfg = '0;
    logic                        want_b = 1'b0;
    logic                        dyn_sel;
    logic [3:0]                  regional_cfg = 4'h0;
    logic [3:0]                  ext_cfg = 4'h0;
    logic                        ext_use_clock = 1'b1;
    logic                        ext_internal_sig = 1'b0;
    logic [23:0]                 quad_clk = 24'h000000;
    logic [39:0]                 ioclk_cfg = 40'h0;
    logic                        global_out, regional_out, ext_pin_out;
    logic [7:0]                  ioclk_out;
    logic [3:0]                  global_sel_q;
    int                          n_errors = 0, checks_done = 0, cycles = 0;
    clock_source_select_control DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .src_in(src_in), .global_cfg(global_cfg), .dyn_sel(dyn_sel),
        .regional_cfg(regional_cfg), .ext_cfg(ext_cfg),
        .ext_use_clock(ext_use_clock), .ext_internal_sig(ext_internal_sig),
        .quad_clk(quad_clk), .ioclk_cfg(ioclk_cfg), .global_out(global_out),
        .regional_out(regional_out), .ext_pin_out(ext_pin_out),
        .ioclk_out(ioclk_out), .global_sel_q(global_sel_q));
    sel_driver user_side (.sys_clk(sys_clk), .want_b(want_b),
        .dyn_sel(dyn_sel));
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic static_sel();
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk);
            global_cfg <= '{4'h0, 4'h0, 1'b0, 4'(i)};
            regional_cfg <= 4'(i);
            ext_cfg <= 4'(i);
            src_in <= 12'h001 << i;
            want_b <= ~want_b;
            step(3);
            `CHK(global_sel_q, 4'(i))
            `CHK(global_out, 1'b1)
            `CHK(regional_out, 1'b1)
            `CHK(ext_pin_out, 1'b1)
        end
    endtask
    task automatic run_pair(input logic [3:0] b, ea, eb);
        @(posedge sys_clk);
        global_cfg <= '{4'h0, b, 1'b1, 4'h3};
        src_in <= 12'h001 << eb;
        want_b <= 1'b1;
        step(4);
        `CHK(global_sel_q, eb)
        `CHK(global_out, 1'b1)
        @(posedge sys_clk);
        want_b <= 1'b0;
        step(4);
        `CHK(global_sel_q, ea)
        `CHK(global_out, ea == eb)
    endtask
    task automatic ext_internal();
        @(posedge sys_clk);
        ext_use_clock <= 1'b0;
        ext_internal_sig <= 1'b1;
        src_in <= 12'h000;
        step(1);
        `CHK(ext_pin_out, 1'b1)
    endtask
    task automatic io_picks();
        @(posedge sys_clk);
        quad_clk <= 24'hAAAAAA;
        for (int g = 0; g < 8; g++) ioclk_cfg[5*g+:5] <= 5'(3 * g);
        step(1);
        `CHK(ioclk_out, 8'hAA)
        @(posedge sys_clk);
        for (int g = 0; g < 8; g++) ioclk_cfg[5*g+:5] <= 5'(23 + g[0]);
        step(1);
        `CHK(ioclk_out, 8'h55)
    endtask
    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        static_sel();
        run_pair(4'h9, 4'h0, 4'h9);
        run_pair(4'h1, 4'h0, 4'h1);
        run_pair(4'h4, 4'h3, 4'h3);
        ext_internal();
        io_picks();
        conclude();
    end
endmodule
